// [rtl/pmc_pkg.sv]
// Package for the power mode controller: register map, field layout, keys, timing.
// Assumes a single 100 MHz clock and a plain address/strobe register port.

package pmc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_UNLOCK = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_RESET_CAUSE = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hC;

    // ------------------------------------------------------------------
    // Fields
    // ------------------------------------------------------------------
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_MODE_MSB = 2;
    localparam int CTRL_PREC_BIT = 6;
    localparam logic [2:0] SEL_ACTIVE = 3'h0;
    localparam logic [2:0] SEL_HALT = 3'h3;
    localparam logic [2:0] SEL_HIBERNATE = 3'h5;
    localparam logic [15:0] KEY_FIRST = 16'h4859;
    localparam logic [15:0] KEY_SECOND = 16'hF27B;
    localparam int RCAUSE_POR_BIT = 0;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int POR_DELAY_NS = 1000;
    localparam int POR_DELAY_CYC = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POR_CNT_W = 8;
    localparam logic [POR_CNT_W-1:0] POR_LAST = POR_CNT_W'(POR_DELAY_CYC - 1);

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_ACTIVE = 4'b0001,
        ST_HALT = 4'b0010,
        ST_HIBERNATE = 4'b0100,
        ST_WAKE = 4'b1000
    } pmc_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } pmc_bus_req_t;

    typedef struct packed {
        logic core_clk_en;
        logic mem_clk_en;
        logic periph_clk_en;
        logic root_clk_en;
        logic adc_clk_en;
        logic hf_osc_en;
        logic osc_low_precision;
        logic main_reg_en;
        logic retention_reg_en;
        logic flash_power_en;
        logic sram_power_en;
    } pmc_power_t;

endpackage : pmc_pkg

// [rtl/pmc_power_mode_controller.sv]
// Power mode controller: mode register behind a two-write key, clock gating,
// regulator handover, flash power gating, power-on reset stretch and cause flag.
// Assumes core sleep signals and wake requests are asynchronous to clock.
//
// Local design decision: the address-and-strobe port.

`timescale 1ns/1ns
`default_nettype none

module pmc_power_mode_controller
(
    input wire logic clock,
    input wire logic arst_n,
    input wire pmc_pkg::pmc_bus_req_t bus_req,
    output logic [15:0] rdata,
    input wire logic core_sleeping,
    input wire logic deep_sleep_select,
    input wire logic irq_activity,
    input wire logic hib_wake_req,
    output pmc_pkg::pmc_power_t power,
    output logic core_rst_n
);
    import pmc_pkg::*;

    // ------------------------------------------------------------------
    // Reset release and input synchronisers
    // ------------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic rst_n;
    logic [1:0] sleep_sync_r;
    logic [1:0] deep_sync_r;
    logic [1:0] irq_sync_r;
    logic [1:0] hwake_sync_r;
    logic sleeping;
    logic deep;
    logic irq_seen;
    logic hib_wake;

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_sync_r <= 2'h0;
        end
        else
        begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sleep_sync_r <= 2'h0;
            deep_sync_r <= 2'h0;
            irq_sync_r <= 2'h0;
            hwake_sync_r <= 2'h0;
        end
        else
        begin
            sleep_sync_r <= {sleep_sync_r[0], core_sleeping};
            deep_sync_r <= {deep_sync_r[0], deep_sleep_select};
            irq_sync_r <= {irq_sync_r[0], irq_activity};
            hwake_sync_r <= {hwake_sync_r[0], hib_wake_req};
        end
    end
    assign sleeping = sleep_sync_r[1];
    assign deep = deep_sync_r[1];
    assign irq_seen = irq_sync_r[1];
    assign hib_wake = hwake_sync_r[1];

    // ------------------------------------------------------------------
    // Power-on reset stretch and cause flag
    // ------------------------------------------------------------------
    logic [POR_CNT_W-1:0] por_cnt_r;
    logic core_rst_n_r;
    logic por_flag_r;
    logic cause_clear;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            por_cnt_r <= '0;
            core_rst_n_r <= 1'b0;
        end
        else if (!core_rst_n_r)
        begin
            if (por_cnt_r == POR_LAST)
            begin
                core_rst_n_r <= 1'b1;
            end
            por_cnt_r <= por_cnt_r + 1'b1;
        end
    end

    // Write one to clear; power-on always leaves it set
    assign cause_clear = bus_req.wr && (bus_req.addr == OFS_RESET_CAUSE) && bus_req.wdata[RCAUSE_POR_BIT];
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            por_flag_r <= 1'b1;
        end
        else if (cause_clear)
        begin
            por_flag_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Key sequence and mode register
    // ------------------------------------------------------------------
    logic key_half_r;
    logic unlocked_r;
    logic [7:0] control_r;
    logic ctrl_wr;
    logic key_wr;

    assign key_wr = bus_req.wr && (bus_req.addr == OFS_UNLOCK);
    assign ctrl_wr = bus_req.wr && (bus_req.addr == OFS_CONTROL);

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            key_half_r <= 1'b0;
            unlocked_r <= 1'b0;
        end
        else if (key_wr)
        begin
            key_half_r <= (bus_req.wdata == KEY_FIRST);
            unlocked_r <= key_half_r && (bus_req.wdata == KEY_SECOND);
        end
        else if (bus_req.wr)
        begin
            // Any other write consumes or cancels the unlock
            key_half_r <= 1'b0;
            unlocked_r <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            control_r <= CONTROL_RESET;
        end
        else if (ctrl_wr && unlocked_r)
        begin
            control_r <= bus_req.wdata[7:0];
        end
    end

    // ------------------------------------------------------------------
    // Mode sequencer
    // ------------------------------------------------------------------
    pmc_state_t state_r;
    pmc_state_t state_nxt;
    logic [2:0] sel;

    assign sel = control_r[CTRL_MODE_MSB:CTRL_MODE_LSB];

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_ACTIVE:
            begin
                // Deep sleep flag only matters for hibernate; halt ignores it
                if (sleeping && sel == SEL_HALT)
                begin
                    state_nxt = ST_HALT;
                end
                else if (sleeping && deep && sel == SEL_HIBERNATE)
                begin
                    state_nxt = ST_HIBERNATE;
                end
            end
            ST_HALT:
            begin
                if (irq_seen || !sleeping)
                begin
                    state_nxt = ST_ACTIVE;
                end
            end
            ST_HIBERNATE:
            begin
                if (hib_wake)
                begin
                    state_nxt = ST_WAKE;
                end
            end
            ST_WAKE:
            begin
                // One cycle on the main regulator before clocks return
                state_nxt = ST_ACTIVE;
            end
            default:
            begin
                state_nxt = ST_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= ST_ACTIVE;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Clock, oscillator and supply controls
    // ------------------------------------------------------------------
    pmc_power_t power_r;
    logic hib_nxt;
    logic gated_nxt;
    logic wake_nxt;

    assign hib_nxt = (state_nxt == ST_HIBERNATE);
    assign wake_nxt = (state_nxt == ST_WAKE);
    assign gated_nxt = hib_nxt || wake_nxt;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            power_r <= '1;
            power_r.osc_low_precision <= 1'b0;
            power_r.retention_reg_en <= 1'b0;
        end
        else
        begin
            power_r.core_clk_en <= !gated_nxt;
            power_r.mem_clk_en <= (state_nxt == ST_ACTIVE);
            power_r.periph_clk_en <= (state_nxt == ST_ACTIVE);
            power_r.root_clk_en <= !gated_nxt;
            power_r.adc_clk_en <= !gated_nxt;
            power_r.hf_osc_en <= !hib_nxt;
            power_r.osc_low_precision <= control_r[CTRL_PREC_BIT];
            power_r.main_reg_en <= !hib_nxt;
            power_r.retention_reg_en <= hib_nxt;
            power_r.flash_power_en <= !gated_nxt;
            power_r.sram_power_en <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------
    logic [15:0] rdata_r;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_r <= 16'h0000;
        end
        else if (bus_req.rd)
        begin
            unique case (bus_req.addr)
                OFS_CONTROL: rdata_r <= {8'h00, control_r};
                OFS_RESET_CAUSE: rdata_r <= {15'h0000, por_flag_r};
                OFS_STATUS: rdata_r <= {12'h000, state_r};
                default: rdata_r <= 16'h0000;
            endcase
        end
        else
        begin
            rdata_r <= 16'h0000;
        end
    end

    assign rdata = rdata_r;
    assign power = power_r;
    assign core_rst_n = core_rst_n_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence enter_hib_s;
        state_r == ST_ACTIVE && state_nxt == ST_HIBERNATE;
    endsequence

    hib_regulator_a: assert property (@(posedge clock) disable iff (!rst_n)
        enter_hib_s |=> power_r.retention_reg_en && !power_r.main_reg_en)
        else $error("regulator not handed over on hibernate");

    active_regulator_a: assert property (@(posedge clock) disable iff (!rst_n)
        (state_r == ST_ACTIVE && $past(state_r) == ST_ACTIVE) |-> power_r.main_reg_en && !power_r.retention_reg_en)
        else $error("main regulator off in active");

    halt_gating_a: assert property (@(posedge clock) disable iff (!rst_n)
        (state_r == ST_HALT) |-> !power_r.mem_clk_en && !power_r.periph_clk_en && power_r.core_clk_en)
        else $error("halt clock gating wrong");

    halt_wake_a: assert property (@(posedge clock) disable iff (!rst_n)
        (state_r == ST_HALT && irq_seen) |=> state_r == ST_ACTIVE && power_r.mem_clk_en && power_r.periph_clk_en)
        else $error("halt did not wake on interrupt");

    hib_flash_a: assert property (@(posedge clock) disable iff (!rst_n)
        enter_hib_s |=> !power_r.flash_power_en && power_r.sram_power_en)
        else $error("flash power not gated in hibernate");

    hib_clocks_a: assert property (@(posedge clock) disable iff (!rst_n)
        (state_r == ST_HIBERNATE) |-> !power_r.core_clk_en && !power_r.hf_osc_en)
        else $error("hibernate clocks running");

    hib_wake_only_a: assert property (@(posedge clock) disable iff (!rst_n)
        (state_r == ST_HIBERNATE && !hib_wake) |=> state_r == ST_HIBERNATE)
        else $error("hibernate left without wake source");

    wake_restore_a: assert property (@(posedge clock) disable iff (!rst_n)
        (state_r == ST_WAKE) |=> state_r == ST_ACTIVE && power_r.core_clk_en && power_r.flash_power_en && power_r.hf_osc_en)
        else $error("wake did not restore active");

    locked_write_a: assert property (@(posedge clock) disable iff (!rst_n)
        (ctrl_wr && !unlocked_r) |=> $stable(control_r))
        else $error("mode written without key");

    unlock_once_a: assert property (@(posedge clock) disable iff (!rst_n)
        ctrl_wr |=> !unlocked_r)
        else $error("unlock survived a mode write");

    por_release_a: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(core_rst_n_r) |-> por_cnt_r == POR_CNT_W'(POR_DELAY_CYC))
        else $error("core reset released at wrong time");

    halt_deep_a: assert property (@(posedge clock) disable iff (!rst_n)
        (state_r == ST_ACTIVE && sleeping && sel == SEL_HALT) |=> state_r == ST_HALT)
        else $error("deep sleep disturbed halt entry");

    sel_stable_a: assert property (@(posedge clock) disable iff (!rst_n)
        (!ctrl_wr) |=> $stable(control_r))
        else $error("selected mode changed without write");

endmodule // pmc_power_mode_controller

`default_nettype wire

// [dv/pmc_core_model.sv]
// Behavioural core and interrupt side: sleep entry, deep sleep bit and wake lines.
// Assumes the bench drives the command inputs by non-blocking assignment at a rising edge.
`timescale 1ns/1ns
`default_nettype none
module pmc_core_model
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic wfi,
    input wire logic deep_bit,
    input wire logic irq_req,
    input wire logic wake_req,
    input wire logic core_clk_en,
    output logic core_sleeping,
    output logic deep_sleep_select,
    output logic irq_activity,
    output logic hib_wake_req
);
    // Deep sleep follows bit 2 of the core's control register
    assign deep_sleep_select = deep_bit;
    assign irq_activity = irq_req;
    assign hib_wake_req = wake_req;
    // A stopped core clock leaves the interrupt controller unable to wake the core
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            core_sleeping <= 1'b0;
        else if (wake_req || (irq_req && core_clk_en))
            core_sleeping <= 1'b0;
        else if (wfi)
            core_sleeping <= 1'b1;
    end
endmodule // pmc_core_model
`default_nettype wire

// [dv/tb.sv]
// Self-checking bench for the power mode controller with a behavioural core model.
// Assumes the package constants, the one-hot state code and the power struct layout of the design.
`timescale 1ns/1ns
`default_nettype none
module tb;
    import pmc_pkg::*;
    // Power struct images: active, halt, hibernate (precision bit clear)
    localparam logic [10:0] PW_ACT = 11'h7EB;
    localparam logic [10:0] PW_HALT = 11'h4EB;
    localparam logic [10:0] PW_HIB = 11'h005;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    pmc_bus_req_t bus_req = '0;
    logic [15:0] rdata;
    logic core_sleeping, deep_sleep_select, irq_activity, hib_wake_req, core_rst_n;
    logic wfi = 1'b0;
    logic deep_bit = 1'b0;
    logic irq_req = 1'b0;
    logic wake_req = 1'b0;
    pmc_power_t power;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;

    pmc_power_mode_controller uut (.clock(clock), .arst_n(arst_n), .bus_req(bus_req), .rdata(rdata),
        .core_sleeping(core_sleeping), .deep_sleep_select(deep_sleep_select), .irq_activity(irq_activity),
        .hib_wake_req(hib_wake_req), .power(power), .core_rst_n(core_rst_n));
    pmc_core_model core (.clock(clock), .arst_n(arst_n), .wfi(wfi), .deep_bit(deep_bit), .irq_req(irq_req),
        .wake_req(wake_req), .core_clk_en(power.core_clk_en), .core_sleeping(core_sleeping),
        .deep_sleep_select(deep_sleep_select), .irq_activity(irq_activity), .hib_wake_req(hib_wake_req));

    always #(CLK_PERIOD_NS / 2) clock = ~clock;

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t ns: expected %h, got %h", $time, exp, got);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus_req <= '0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus_req <= '0;
        #1;
        check(exp, rdata);
    endtask

    task automatic unlock(input logic [7:0] v);
        wr(OFS_UNLOCK, KEY_FIRST);
        wr(OFS_UNLOCK, KEY_SECOND);
        wr(OFS_CONTROL, {8'h00, v});
    endtask

    task automatic sleep();
        @(posedge clock);
        wfi <= 1'b1;
        @(posedge clock);
        wfi <= 1'b0;
    endtask

    // Bounded wait: the sleep inputs pass a synchroniser first
    task automatic wait_pw(input logic [10:0] exp);
        int n;
        n = 0;
        while (power !== exp && n < 20)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        check({5'h00, exp}, {5'h00, power});
    endtask

    task automatic hold_pw(input logic [10:0] exp);
        repeat (10)
        begin
            @(posedge clock);
            #1;
            check({5'h00, exp}, {5'h00, power});
        end
    endtask

    task automatic pulse_irq();
        @(posedge clock);
        irq_req <= 1'b1;
        repeat (6) @(posedge clock);
        irq_req <= 1'b0;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Release reset at the next edge, then time the core reset stretch
    task automatic release_por();
        int n;
        n = 0;
        @(posedge clock);
        arst_n <= 1'b1;
        while (core_rst_n !== 1'b1 && n < 200)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        check(16'h0001, {15'h0000, n >= POR_DELAY_CYC && n <= POR_DELAY_CYC + 3});
        rd(OFS_RESET_CAUSE, 16'h0001);
    endtask

    task automatic t_reset();
        repeat (11) @(posedge clock);
        #1;
        check({5'h00, PW_ACT}, {5'h00, power});
        check(16'h0000, {15'h0000, core_rst_n});
        release_por();
        wr(OFS_RESET_CAUSE, 16'h0001);
        rd(OFS_RESET_CAUSE, 16'h0000);
        rd(OFS_CONTROL, {8'h00, CONTROL_RESET});
        rd(4'h2, 16'h0000);
    endtask

    // A second power-on in mid-run must set the cause flag again
    task automatic t_repor();
        @(posedge clock);
        arst_n <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
        check({5'h00, PW_ACT}, {5'h00, power});
        check(16'h0000, {15'h0000, core_rst_n});
        release_por();
        rd(OFS_CONTROL, {8'h00, CONTROL_RESET});
    endtask

    task automatic t_key();
        wr(OFS_CONTROL, 16'h0005);
        rd(OFS_CONTROL, 16'h0000);
        wr(OFS_UNLOCK, KEY_FIRST);
        wr(4'h2, 16'h0000);
        wr(OFS_UNLOCK, KEY_SECOND);
        wr(OFS_CONTROL, 16'h0005);
        rd(OFS_CONTROL, 16'h0000);
        wr(OFS_UNLOCK, KEY_FIRST);
        wr(OFS_UNLOCK, 16'h1234);
        wr(OFS_UNLOCK, KEY_SECOND);
        wr(OFS_CONTROL, 16'h0005);
        rd(OFS_CONTROL, 16'h0000);
        unlock(8'h40);
        rd(OFS_CONTROL, 16'h0040);
        check(16'h0001, {15'h0000, power.osc_low_precision});
        wr(OFS_CONTROL, 16'h0000);
        rd(OFS_CONTROL, 16'h0040);
        unlock(8'h00);
        wait_pw(PW_ACT);
    endtask

    task automatic t_active_sleep();
        deep_bit <= 1'b0;
        sleep();
        hold_pw(PW_ACT);
        pulse_irq();
        rd(OFS_CONTROL, 16'h0000);
    endtask

    task automatic t_halt();
        deep_bit <= 1'b1;
        unlock({5'h00, SEL_HALT});
        sleep();
        wait_pw(PW_HALT);
        rd(OFS_STATUS, 16'h0002);
        @(posedge clock);
        irq_req <= 1'b1;
        wait_pw(PW_ACT);
        @(posedge clock);
        irq_req <= 1'b0;
        rd(OFS_CONTROL, {13'h0000, SEL_HALT});
        deep_bit <= 1'b0;
        sleep();
        wait_pw(PW_HALT);
        pulse_irq();
        wait_pw(PW_ACT);
    endtask

    task automatic t_hibernate();
        deep_bit <= 1'b0;
        unlock({5'h00, SEL_HIBERNATE});
        sleep();
        hold_pw(PW_ACT);
        pulse_irq();
        deep_bit <= 1'b1;
        unlock({5'h00, SEL_HIBERNATE});
        sleep();
        wait_pw(PW_HIB);
        @(posedge clock);
        irq_req <= 1'b1;
        hold_pw(PW_HIB);
        irq_req <= 1'b0;
        @(posedge clock);
        wake_req <= 1'b1;
        wait_pw(PW_ACT);
        @(posedge clock);
        wake_req <= 1'b0;
        rd(OFS_CONTROL, {13'h0000, SEL_HIBERNATE});
    endtask

    // ------------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------------
    task automatic give_verdict();
        if (mismatches == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            give_verdict();
        end
    end

    initial
    begin
        t_reset();
        t_key();
        t_active_sleep();
        t_halt();
        t_hibernate();
        t_repor();
        give_verdict();
    end
endmodule // tb
`default_nettype wire
